// ===== hw/clock_reset_defines.vh
// Register offsets, field positions and reset values of the clock and
// reset generator. Included by the register block; definitions only.
`ifndef CLOCK_RESET_DEFINES_VH
`define CLOCK_RESET_DEFINES_VH
`define OFF_LOOP_MULT 4'h0
`define OFF_REF_DIV 4'h1
`define OFF_POST_DIV 4'h2
`define OFF_FLAGS 4'h3
`define OFF_INT_EN 4'h4
`define OFF_CLK_SEL 4'h5
`define OFF_LOOP_CTL 4'h6
`define OFF_RATE_PERIODIC 4'h7
`define OFF_RATE_WATCHDOG 4'h8
`define OFF_FACT_BYPASS 4'h9
`define OFF_FACT_TEST 4'ha
`define OFF_WD_SERVICE 4'hb
`define OFF_MODE_CTL 4'hc
`define OFF_MODE_STAT 4'hd
`define POS_PLL_SEL 7
`define POS_PSTOP_SEL 6
`define POS_PLL_WAIT 3
`define POS_RTI_WAIT 1
`define POS_COP_WAIT 0
`define POS_CM_EN 7
`define POS_PLL_ON 6
`define POS_SCM_EN 0
`define POS_LOCK 3
`define POS_SCM 0
`define POS_LOCKIF 4
`define POS_SCMIF 1
`define POS_RTIF 7
`define MASK_POST_DIV 8'h1f
`define MASK_INT_EN 8'h92
`define MASK_CLK_SEL 8'heb
`define MASK_WD_CTL 8'hc7
`define MASK_FLAGS_W1C 8'hf6
`define RST_ZERO 8'h00
`define RST_LOOP_CTL 8'hc1
`define RST_FLAGS 8'h40
`define LOCK_TIME_NS 10000
`define CLK_PERIOD_NS 20
`define LOCK_CYCLES (`LOCK_TIME_NS / `CLK_PERIOD_NS)
`define CQC_TIME_NS 20000
`define CQC_CYCLES (`CQC_TIME_NS / `CLK_PERIOD_NS)
`define RESET_PULSE_CYCLES 5'h10
`endif

// ===== hw/clock_reset_generator.v
// Clock and reset generator control core: register file on classic
// Wishbone, low-power mode sequencing, lock detector, self clock mode
// and the open-drain reset pin. Assumes one 50 MHz clock, an analog
// loop and oscillator outside that report lock and clock loss as pins.
//
// Functional notes
// RULE_01 - Software sets nonzero rates to run timers.
// RULE_02 - Wait mode stops loop when pll_off_in_wait.
// RULE_03 - Stop entry picks full or pseudo stop.
// RULE_04 - Full stop halts oscillator, freezes both timers.
// RULE_05 - Pseudo stop: timers run only if enabled.
// RULE_06 - Self clock on monitor loss when enabled.
// RULE_07 - Leave self clock after quality check passes.
// RULE_08 - Low reset pin resets whole device.
// RULE_09 - Internal reset pulls reset pin low.
// RULE_10 - Multiplier writes ignored while pll selected.
// RULE_11 - Divider writes ignored while pll selected.
// RULE_12 - Accepted divider writes restart lock detector.
// RULE_13 - VCO, post divider and bus clock ratios.
// RULE_14 - Software keeps VCO and bus in range.
// RULE_15 - Reference clock is oscillator over divider.
// RULE_16 - Software matches vco_range_select to VCO.
// RULE_17 - Software matches ref_range_select to reference.
// RULE_18 - Factory test registers read zero, unused.
// RULE_19 - Clear pll_clock_select on scm, stop, wait; wait clears it only with pll_off_in_wait.
// RULE_20 - Lock status held clear in self clock.
// RULE_21 - Self clock runs from minimum loop output.
// RULE_22 - Unimplemented bits read zero, writes ignored.
`timescale 1ns/1ps
`include "clock_reset_defines.vh"
module clock_reset_generator #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter CQC_CYCLES = `CQC_CYCLES
) (
  input wire clk_i, // System clock, 50 MHz
  input wire rst_i, // Synchronous reset, active high
  input wire cyc_i, // Wishbone cycle
  input wire stb_i, // Wishbone strobe
  input wire we_i, // Wishbone write enable
  input wire [3:0] adr_i, // Wishbone word address
  input wire [7:0] dat_i, // Wishbone write data
  input wire sel_i, // Wishbone byte select
  output reg [7:0] dat_o, // Wishbone read data
  output reg ack_o, // Wishbone acknowledge
  input wire wait_req_i, // Core asks for wait mode
  input wire stop_req_i, // Core asks for stop mode
  input wire wake_i, // Wake event ends wait or stop
  input wire pll_lock_raw_i, // Analog loop frequency in tolerance
  input wire osc_loss_i, // Oscillator monitor reports loss
  input wire osc_good_i, // Quality check: frequency and amplitude ok
  input wire int_reset_req_i, // Internal system reset source
  input wire reset_pin_i, // Reset pin level
  output reg reset_pin_o, // Reset pin drive value, always low
  output reg reset_pin_oe_o, // Reset pin enable, pulls low
  output reg system_reset_o, // Device-wide reset
  output reg osc_enable_o, // Oscillator enable
  output reg pll_enable_o, // Loop enable
  output reg core_clk_en_o, // Core and system clocks running
  output reg sys_from_pll_o, // System clock taken from loop
  output reg scm_clk_o, // Loop forced to self clock minimum
  output reg wd_run_o, // Watchdog may count
  output reg rti_run_o, // Periodic timer may count
  output reg [5:0] loop_mult_o, // loop_multiplier to analog loop
  output reg [5:0] ref_div_o, // ref_divider_value to loop
  output reg [4:0] post_div_o, // post_divider_value to loop
  output reg [1:0] vco_range_o, // vco_range_select to loop
  output reg [1:0] ref_range_o, // ref_range_select to loop
  output reg [7:0] wd_rate_o, // Watchdog rate field
  output reg [7:0] rti_rate_o, // Periodic rate field
  output reg wd_service_o // One-cycle pulse on watchdog service write
);
  localparam ST_RUN = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_FSTOP = 4'b0100;
  localparam ST_PSTOP = 4'b1000;
  reg [7:0] loop_multiplier_reg;
  reg [7:0] reference_divider_reg;
  reg [7:0] post_divider_reg;
  reg [7:0] clock_flags_reg;
  reg [7:0] clock_interrupt_enable_reg;
  reg [7:0] clock_select_reg;
  reg [7:0] loop_control_reg;
  reg [7:0] periodic_rate_control_reg;
  reg [7:0] watchdog_rate_control_reg;
  reg [7:0] mode_control_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg scm_reg;
  reg lock_reg;
  reg [15:0] lock_cnt_reg;
  reg [15:0] cqc_cnt_reg;
  reg [2:0] lock_sync_reg;
  reg [2:0] loss_sync_reg;
  reg [2:0] good_sync_reg;
  reg [2:0] pin_sync_reg;
  reg [4:0] pulse_cnt_reg;
  reg wd_write_once_reg;
  wire wr;
  wire lock_in;
  wire loss_in;
  wire good_in;
  wire pin_low;
  wire pll_sel;
  wire scm_enter;
  wire scm_leave;
  wire lock_restart;
  wire pll_gate;
  wire acc;
  reg [7:0] rd_data;
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = acc & we_i & sel_i;
  assign pll_sel = clock_select_reg[`POS_PLL_SEL];
  // An input counts as active only when the second and third stages agree; either stage going inactive drops it.
  assign lock_in = lock_sync_reg[1] & lock_sync_reg[2];
  assign loss_in = loss_sync_reg[1] & loss_sync_reg[2];
  assign good_in = good_sync_reg[1] & good_sync_reg[2];
  assign pin_low = ~pin_sync_reg[1] & ~pin_sync_reg[2];
  assign scm_enter = ~scm_reg & loss_in & loop_control_reg[`POS_CM_EN]
    & loop_control_reg[`POS_SCM_EN]; // RULE_06
  assign scm_leave = scm_reg & good_in &
    (cqc_cnt_reg == 16'h0000); // RULE_07
  assign lock_restart = wr & ~pll_sel &
    ((adr_i == `OFF_LOOP_MULT) | (adr_i == `OFF_REF_DIV)); // RULE_12
  assign pll_gate = loop_control_reg[`POS_PLL_ON] &
    ~(state_reg == ST_FSTOP) &
    ~((state_reg == ST_WAIT) & clock_select_reg[`POS_PLL_WAIT]);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (stop_req_i)
          state_next = clock_select_reg[`POS_PSTOP_SEL] ?
            ST_PSTOP : ST_FSTOP; // RULE_03
        else if (wait_req_i)
          state_next = ST_WAIT;
      ST_WAIT, ST_FSTOP, ST_PSTOP:
        if (wake_i)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always @*
  begin
    case (adr_i)
      `OFF_LOOP_MULT: rd_data = loop_multiplier_reg;
      `OFF_REF_DIV: rd_data = reference_divider_reg;
      `OFF_POST_DIV: rd_data = post_divider_reg;
      `OFF_FLAGS: rd_data = {clock_flags_reg[7:4], lock_reg,
        clock_flags_reg[2:1], scm_reg};
      `OFF_INT_EN: rd_data = clock_interrupt_enable_reg;
      `OFF_CLK_SEL: rd_data = clock_select_reg;
      `OFF_LOOP_CTL: rd_data = loop_control_reg;
      `OFF_RATE_PERIODIC: rd_data = periodic_rate_control_reg;
      `OFF_RATE_WATCHDOG: rd_data = watchdog_rate_control_reg;
      `OFF_MODE_CTL: rd_data = mode_control_reg;
      `OFF_MODE_STAT: rd_data = {4'h0, state_reg};
      default: rd_data = `RST_ZERO; // RULE_18
    endcase
  end

  always @(posedge clk_i)
  begin
    lock_sync_reg <= {lock_sync_reg[1:0], pll_lock_raw_i};
    loss_sync_reg <= {loss_sync_reg[1:0], osc_loss_i};
    good_sync_reg <= {good_sync_reg[1:0], osc_good_i};
    pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_i};
  end

  // The pin reset acts through the synchroniser; the pad cell itself
  // is expected to gate clocks asynchronously in a real chip.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      system_reset_o <= 1'b1;
      pulse_cnt_reg <= 5'h00;
      reset_pin_oe_o <= 1'b0;
    end
    else if (int_reset_req_i)
    begin
      system_reset_o <= 1'b1;
      pulse_cnt_reg <= `RESET_PULSE_CYCLES;
      reset_pin_oe_o <= 1'b1; // RULE_09
    end
    else if (pulse_cnt_reg != 5'h00)
    begin
      pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
      reset_pin_oe_o <= 1'b1; // RULE_09
      system_reset_o <= 1'b1;
    end
    else
    begin
      // Our own pull is still seen on the pin for a few cycles after
      // release, so a low pin must never re-arm the pull itself.
      reset_pin_oe_o <= 1'b0;
      system_reset_o <= pin_low; // RULE_08
    end
    reset_pin_o <= 1'b0;
  end

  always @(posedge clk_i)
  begin
    if (rst_i | system_reset_o)
    begin
      loop_multiplier_reg <= `RST_ZERO;
      reference_divider_reg <= `RST_ZERO;
      post_divider_reg <= `RST_ZERO;
      clock_flags_reg <= rst_i ? `RST_FLAGS : clock_flags_reg;
      clock_interrupt_enable_reg <= `RST_ZERO;
      clock_select_reg <= `RST_ZERO;
      loop_control_reg <= `RST_LOOP_CTL;
      periodic_rate_control_reg <= `RST_ZERO;
      watchdog_rate_control_reg <= `RST_ZERO;
      mode_control_reg <= `RST_ZERO;
      wd_write_once_reg <= 1'b0;
      state_reg <= ST_RUN;
      scm_reg <= 1'b0;
      lock_reg <= 1'b0;
      lock_cnt_reg <= LOCK_CYCLES[15:0];
      cqc_cnt_reg <= 16'h0000;
      ack_o <= 1'b0;
      dat_o <= `RST_ZERO;
      wd_service_o <= 1'b0;
    end
    else
    begin
      ack_o <= acc;
      dat_o <= acc & ~we_i ? rd_data : `RST_ZERO;
      wd_service_o <= wr & (adr_i == `OFF_WD_SERVICE);
      state_reg <= state_next;
      if (wr)
        case (adr_i)
          `OFF_LOOP_MULT:
            if (~pll_sel)
              loop_multiplier_reg <= dat_i; // RULE_10
          `OFF_REF_DIV:
            if (~pll_sel)
              reference_divider_reg <= dat_i; // RULE_11
          `OFF_POST_DIV:
            if (~pll_sel)
              post_divider_reg <= dat_i & `MASK_POST_DIV; // RULE_22
          `OFF_INT_EN:
            clock_interrupt_enable_reg <= dat_i & `MASK_INT_EN;
          `OFF_LOOP_CTL: loop_control_reg <= dat_i;
          `OFF_RATE_PERIODIC: periodic_rate_control_reg <= dat_i;
          `OFF_RATE_WATCHDOG:
            if (~wd_write_once_reg)
            begin
              watchdog_rate_control_reg <= dat_i & `MASK_WD_CTL;
              wd_write_once_reg <= 1'b1;
            end
          `OFF_MODE_CTL: mode_control_reg <= dat_i;
          default: ;
        endcase
      // Select is refused without lock and dropped in self clock, on stop entry and on wait entry with pll_off_in_wait.
      if (scm_enter | scm_reg | (state_next == ST_FSTOP) |
          (state_next == ST_PSTOP) | ((state_next == ST_WAIT) &
          clock_select_reg[`POS_PLL_WAIT]))
        clock_select_reg[`POS_PLL_SEL] <= 1'b0; // RULE_19
      else if (wr & (adr_i == `OFF_CLK_SEL))
        clock_select_reg <= (dat_i & `MASK_CLK_SEL) &
          {lock_reg, 7'h7f};
      if (scm_enter)
      begin
        scm_reg <= 1'b1; // RULE_06
        cqc_cnt_reg <= CQC_CYCLES[15:0];
      end
      else if (scm_leave)
        scm_reg <= 1'b0; // RULE_07
      else if (scm_reg & (cqc_cnt_reg != 16'h0000))
        cqc_cnt_reg <= cqc_cnt_reg - 16'h0001;
      else if (scm_reg & ~good_in)
        cqc_cnt_reg <= CQC_CYCLES[15:0];
      // Lock needs the raw lock held for the whole window.
      if (lock_restart | scm_reg | ~lock_in | ~pll_gate)
      begin
        lock_cnt_reg <= LOCK_CYCLES[15:0]; // RULE_12
        lock_reg <= 1'b0; // RULE_20
      end
      else if (lock_cnt_reg != 16'h0000)
        lock_cnt_reg <= lock_cnt_reg - 16'h0001;
      else
        lock_reg <= 1'b1;
      // Set wins over a same-cycle write-one clear.
      clock_flags_reg <= (clock_flags_reg & ~(wr & (adr_i == `OFF_FLAGS)
        ? dat_i & `MASK_FLAGS_W1C : 8'h00)) |
        {1'b0, 2'b00, (lock_reg != (lock_cnt_reg == 16'h0000 &
        ~lock_restart & ~scm_reg & lock_in & pll_gate)), 2'b00,
        scm_enter | scm_leave, 1'b0};
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_enable_o <= 1'b1;
      pll_enable_o <= 1'b0;
      core_clk_en_o <= 1'b1;
      sys_from_pll_o <= 1'b0;
      scm_clk_o <= 1'b0;
      wd_run_o <= 1'b0;
      rti_run_o <= 1'b0;
      loop_mult_o <= 6'h00;
      ref_div_o <= 6'h00;
      post_div_o <= 5'h00;
      vco_range_o <= 2'b00;
      ref_range_o <= 2'b00;
      wd_rate_o <= `RST_ZERO;
      rti_rate_o <= `RST_ZERO;
    end
    else
    begin
      osc_enable_o <= state_reg != ST_FSTOP; // RULE_04
      pll_enable_o <= pll_gate | scm_reg; // RULE_02
      core_clk_en_o <= state_reg == ST_RUN | state_reg == ST_WAIT;
      sys_from_pll_o <= pll_sel | scm_reg; // RULE_21
      scm_clk_o <= scm_reg; // RULE_21
      // Timers count only with a nonzero rate; software enables them.
      wd_run_o <= (watchdog_rate_control_reg[2:0] != 3'b000) &
        ((state_reg == ST_RUN) |
        ((state_reg == ST_WAIT) & ~clock_select_reg[`POS_COP_WAIT]) |
        ((state_reg == ST_PSTOP) &
        mode_control_reg[`POS_COP_WAIT])); // RULE_05
      rti_run_o <= (periodic_rate_control_reg[6:0] != 7'h00) &
        ((state_reg == ST_RUN) |
        ((state_reg == ST_WAIT) & ~clock_select_reg[`POS_RTI_WAIT]) |
        ((state_reg == ST_PSTOP) &
        mode_control_reg[`POS_RTI_WAIT])); // RULE_05
      // Ratios realised by the analog loop. RULE_13 RULE_15
      loop_mult_o <= loop_multiplier_reg[5:0]; // RULE_13
      ref_div_o <= reference_divider_reg[5:0]; // RULE_15
      post_div_o <= post_divider_reg[4:0]; // RULE_13
      vco_range_o <= loop_multiplier_reg[7:6];
      ref_range_o <= reference_divider_reg[7:6];
      wd_rate_o <= watchdog_rate_control_reg;
      rti_rate_o <= periodic_rate_control_reg;
    end
  end
endmodule // clock_reset_generator

// ===== bench/board_model.sv
// Board side of the generator: reset pin with pull-up and push button,
// crystal oscillator with its monitor and the analog loop's lock.
// Assumes the bench drives the scenario inputs just after clock edges.
`timescale 1ns/1ps
module board_model (
  input wire logic clk_i, // System clock
  input wire logic pin_oe_i, // Generator pulls the pin low
  input wire logic press_i, // Button holds the pin low
  input wire logic osc_dead_i, // Crystal has stopped
  input wire logic loop_ok_i, // Loop sits at its target
  output logic pin_o, // Resolved pin level
  output logic loss_o, // Monitor reports loss
  output logic good_o, // Quality check result
  output logic lock_o // Loop in tolerance
);
  logic [2:0] settle_reg = 3'h0;
  // Open drain with pull-up: high unless someone pulls it down.
  assign pin_o = !(pin_oe_i || press_i);
  assign loss_o = osc_dead_i;
  assign lock_o = loop_ok_i;
  // A restarted crystal needs a few cycles before it passes the check.
  always @(posedge clk_i)
    if (osc_dead_i)
      settle_reg <= 3'h0;
    else if (settle_reg != 3'h7)
      settle_reg <= settle_reg + 3'h1;
  assign good_o = settle_reg == 3'h7;
endmodule // board_model

// ===== bench/crg_chk.sv
// Port assertions for the clock and reset generator.
// Assumes one clock and the synchronous reset of the generator.
`timescale 1ns/1ps
module crg_chk (
  input wire clk_i, rst_i, cyc_i, stb_i, we_i, sel_i, ack_o, // Bus
  input wire [3:0] adr_i, // Address
  input wire [7:0] dat_i, dat_o, // Data
  input wire int_reset_req_i, reset_pin_o, reset_pin_oe_o, // Reset
  input wire system_reset_o, osc_enable_o, core_clk_en_o, // Modes
  input wire sys_from_pll_o, scm_clk_o, wd_run_o, rti_run_o, // Clocks
  input wire [5:0] loop_mult_o, ref_div_o, // Loop
  input wire [1:0] ref_range_o // Range
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o;
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (req |=> ack_o)
    else $error("request not answered");
  a_pin_pull: assert property (int_reset_req_i |-> ##[1:2] reset_pin_oe_o)
    else $error("reset pin not pulled");
  a_pin_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
    else $error("reset pin driven high");
  a_int_resets: assert property (int_reset_req_i |-> ##[1:3] system_reset_o)
    else $error("internal reset not applied");
  a_scm_no_lock: assert property (ack_o && !$past(we_i) && $past(adr_i) == 4'h3
    && $past(scm_clk_o) && $past(scm_clk_o, 2) |-> !dat_o[3])
    else $error("lock shown in self clock");
  a_factory_zero: assert property (ack_o && !$past(we_i) &&
    ($past(adr_i) == 4'h9 || $past(adr_i) == 4'ha) |-> dat_o == 8'h00)
    else $error("factory register not zero");
  a_mult_kept: assert property (req && we_i && adr_i == 4'h0 && sys_from_pll_o
    |=> $stable(loop_mult_o)[*3])
    else $error("multiplier changed while loop selected");
  a_div_lands: assert property (req && we_i && sel_i && adr_i == 4'h1 &&
    !sys_from_pll_o |=> ##1 {ref_range_o, ref_div_o} == $past(dat_i, 2))
    else $error("divider write not applied");
  a_stop_freeze: assert property (!osc_enable_o |->
    !core_clk_en_o && !wd_run_o && !rti_run_o)
    else $error("clocks or timers run with oscillator off");
endmodule // crg_chk
bind clock_reset_generator crg_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .ack_o(ack_o),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .int_reset_req_i(int_reset_req_i), .reset_pin_o(reset_pin_o),
  .reset_pin_oe_o(reset_pin_oe_o), .system_reset_o(system_reset_o),
  .osc_enable_o(osc_enable_o), .core_clk_en_o(core_clk_en_o),
  .sys_from_pll_o(sys_from_pll_o), .scm_clk_o(scm_clk_o),
  .wd_run_o(wd_run_o), .rti_run_o(rti_run_o), .loop_mult_o(loop_mult_o),
  .ref_div_o(ref_div_o), .ref_range_o(ref_range_o));

// ===== bench/clock_reset_generator_pll_config_test.sv
// Self-checking bench: Wishbone register accesses and mode scenarios.
// Assumes the board model on the far side and short lock/check counts.
`timescale 1ns/1ps
module clock_reset_generator_pll_config_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sel_i = 1'b1;
  logic wait_req_i = 1'b0, stop_req_i = 1'b0, wake_i = 1'b0;
  logic int_reset_req_i = 1'b0, press = 1'b0, dead = 1'b0, loop_ok = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [7:0] dat_i = 8'h00;
  logic [3:0] stop_exp [3] = '{4'h0, 4'hb, 4'h8};
  wire [7:0] dat_o;
  wire ack_o, reset_pin_o, reset_pin_oe_o, system_reset_o, osc_enable_o;
  wire pll_enable_o, core_clk_en_o, sys_from_pll_o, scm_clk_o;
  wire wd_run_o, rti_run_o, wd_service_o, pin, loss, good, lock;
  wire [5:0] loop_mult_o, ref_div_o;
  wire [4:0] post_div_o;
  wire [1:0] vco_range_o;
  wire [7:0] wd_rate_o, rti_rate_o;
  int err_total = 0, total_checks = 0;
  clock_reset_generator #(.LOCK_CYCLES(8), .CQC_CYCLES(8)) dut_u (.*,
    .pll_lock_raw_i(lock), .osc_loss_i(loss), .osc_good_i(good),
    .reset_pin_i(pin), .ref_range_o());
  board_model board_u (.clk_i(clk_i), .pin_oe_i(reset_pin_oe_o),
    .press_i(press), .osc_dead_i(dead), .loop_ok_i(loop_ok),
    .pin_o(pin), .loss_o(loss), .good_o(good), .lock_o(lock));
  always #10 clk_i = ~clk_i;
  task stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic xf(input logic w, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xf(1'b1, a, d, q);
  endtask
  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    xf(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  task leave;
    stop_req_i <= 1'b0;
    wait_req_i <= 1'b0;
    wake_i <= 1'b1;
    wt(4);
    wake_i <= 1'b0;
    wt(4);
  endtask
  initial
  begin
    wt(3);
    rst_i <= 1'b0;
    wt(4);
    rc(4'h6, 8'hff, 8'hc1);
    rc(4'h3, 8'hff, 8'h40);
    rc(4'h9, 8'hff, 8'h00);
    rc(4'ha, 8'hff, 8'h00);
    rc(4'he, 8'hff, 8'h00);
    wr(4'h2, 8'hff);
    rc(4'h2, 8'hff, 8'h1f);
    wr(4'h0, 8'h45);
    wr(4'h1, 8'h41);
    wt(2);
    chk({2'b00, loop_mult_o}, 8'h05);
    chk({2'b00, ref_div_o}, 8'h01);
    chk({1'b0, vco_range_o, post_div_o}, 8'h3f);
    loop_ok <= 1'b1;
    wt(30);
    rc(4'h3, 8'h08, 8'h08);
    wr(4'h5, 8'h80);
    wr(4'h0, 8'h12);
    rc(4'h0, 8'hff, 8'h45);
    wr(4'h1, 8'h12);
    rc(4'h1, 8'hff, 8'h41);
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h46);
    rc(4'h3, 8'h08, 8'h00);
    // Nonzero rates, as software must set before the timers may run.
    wr(4'h7, 8'h11);
    wr(4'h8, 8'h01);
    wt(30);
    chk(rti_rate_o, 8'h11);
    chk(wd_rate_o, 8'h01);
    wr(4'hb, 8'h00);
    chk({7'h00, wd_service_o}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h5, i == 0 ? 8'h80 : 8'h40);
      wr(4'hc, i == 2 ? 8'h00 : 8'h03);
      stop_req_i <= 1'b1;
      wt(10);
      chk({4'h0, osc_enable_o, core_clk_en_o, wd_run_o, rti_run_o},
        {4'h0, stop_exp[i]});
      leave();
      rc(4'h5, 8'h80, 8'h00);
    end
    for (int j = 0; j < 2; j++)
    begin
      wr(4'h5, j == 0 ? 8'h08 : 8'h00);
      wait_req_i <= 1'b1;
      wt(10);
      chk({7'h00, pll_enable_o}, j);
      leave();
    end
    dead <= 1'b1;
    wt(20);
    chk({7'h00, scm_clk_o}, 8'h01);
    rc(4'h3, 8'h09, 8'h01);
    wt(30);
    chk({7'h00, scm_clk_o}, 8'h01);
    dead <= 1'b0;
    wt(40);
    chk({7'h00, scm_clk_o}, 8'h00);
    press <= 1'b1;
    wt(8);
    chk({7'h00, system_reset_o}, 8'h01);
    press <= 1'b0;
    wt(10);
    rc(4'h0, 8'hff, 8'h00);
    int_reset_req_i <= 1'b1;
    wt(3);
    chk({5'h00, pin, reset_pin_oe_o, system_reset_o}, 8'h03);
    int_reset_req_i <= 1'b0;
    wt(10);
    chk({7'h00, reset_pin_oe_o}, 8'h01);
    wt(20);
    chk({7'h00, reset_pin_oe_o}, 8'h00);
    stop_test();
  end
  initial
  begin
    wt(20000);
    err_total++;
    stop_test();
  end
endmodule // clock_reset_generator_pll_config_test
